/* logic/dsr_cfg.svh */
// offsets, field positions, reset values and ramp constants of the soft ramp block
`ifndef DSR_CFG_SVH
`define DSR_CFG_SVH

// register indices; byte address is four times the index
`define DSR_IDX_PAGE    14'h0008
`define DSR_IDX_SYNC    14'h003B
`define DSR_IDX_IRQMUX  14'h04BC
`define DSR_IDX_GAIN    14'h0580
`define DSR_IDX_OFFEN   14'h0581
`define DSR_IDX_ONEN    14'h0582
`define DSR_IDX_LIMLO   14'h0583
`define DSR_IDX_LIMHI   14'h0584
`define DSR_IDX_LCTRL   14'h0585
`define DSR_IDX_STATUS  14'h05F0

// per path register file: register count and number of paths
`define DSR_PATH_REGS   6
`define DSR_NUM_PATHS   2

// reset values
`define DSR_RST_GAIN    8'h00
`define DSR_RST_OFFEN   8'hC6
`define DSR_RST_ONEN    8'h40
`define DSR_RST_LIMLO   8'h00
`define DSR_RST_LIMHI   8'h00
`define DSR_RST_LCTRL   8'h00
`define DSR_RST_PAGE    8'h03

// writable bit masks
`define DSR_WM_GAIN     8'h87
`define DSR_WM_OFFEN    8'hCF
`define DSR_WM_ONEN     8'hFF
`define DSR_WM_LIMLO    8'hFF
`define DSR_WM_LIMHI    8'h1F
`define DSR_WM_LCTRL    8'h8F
`define DSR_WM_PAGE     8'h03

// field positions
`define DSR_B_GAIN_EN   7
`define DSR_B_SHORT     7
`define DSR_B_LONG      6
`define DSR_B_LINK      3
`define DSR_B_ROT       2
`define DSR_B_TX        1
`define DSR_B_FOFF      0
`define DSR_B_FON       7
`define DSR_B_LVL       6
`define DSR_B_MON       7

// ramp: 32 steps over 2^(code+8) periods, so each step is 2^(code+3)
`define DSR_STEPS       6'd32
`define DSR_STEP_EXP    4'd3

// bus answers
`define DSR_RESP_OKAY   2'b00
`define DSR_RESP_SLVERR 2'b10

`endif

/* logic/dsr_pkg.sv */
// types shared by the soft ramp block
`default_nettype none
package dsr_pkg;

    // ramp states, one-hot
    typedef enum logic [3:0] {
        ST_ON   = 4'b0001,
        ST_DOWN = 4'b0010,
        ST_OFF  = 4'b0100,
        ST_UP   = 4'b1000
    } dsr_state_t;

    // requests presented to one ramp
    typedef struct packed {
        logic ext_off;
        logic force_off;
        logic force_on;
        logic level_on;
    } dsr_req_t;

endpackage : dsr_pkg
`default_nettype wire

/* logic/dsr_ramp.sv */
// gain ramp engine for one main path
`default_nettype none
`include "dsr_cfg.svh"
module dsr_ramp (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // settings
    input  wire logic              gain_en,
    input  wire logic [2:0]        rate,
    input  wire dsr_pkg::dsr_req_t req,
    // ramp result
    output logic [5:0]             step_reg,
    output dsr_pkg::dsr_state_t    state_reg
);
    logic [9:0] cnt_reg;     // cycles within one step
    logic [9:0] period_m1;   // step length minus one
    logic [3:0] exp_sum;     // rate plus step exponent
    logic       tick;        // one step has elapsed

    // step length 2^(code+3) cycles, 32 of them per ramp
    assign exp_sum   = {1'b0, rate} + `DSR_STEP_EXP;
    assign period_m1 = 10'((11'd1 << exp_sum) - 11'd1);
    assign tick      = (cnt_reg == period_m1);

    // step counter idles while gain is settled
    always_ff @(posedge clk) begin
        if (rst || state_reg == dsr_pkg::ST_ON || state_reg == dsr_pkg::ST_OFF) begin
            cnt_reg <= 10'h000;
        end else if (tick) begin
            cnt_reg <= 10'h000;
        end else begin
            cnt_reg <= cnt_reg + 10'h001;
        end
    end

    // ramp sequencing
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= dsr_pkg::ST_ON;
            step_reg  <= `DSR_STEPS;
        end else if (!gain_en) begin
            // ramping disabled: gain passes at full scale
            state_reg <= dsr_pkg::ST_ON;
            step_reg  <= `DSR_STEPS;
        end else begin
            unique case (state_reg)
                dsr_pkg::ST_ON: begin
                    // forced off only counts here, where gain is 1
                    if (req.ext_off || req.force_off) begin
                        state_reg <= dsr_pkg::ST_DOWN;
                    end
                end
                dsr_pkg::ST_DOWN: begin
                    // further off triggers do not restart the ramp
                    if (tick) begin
                        step_reg <= step_reg - 6'd1;
                        if (step_reg == 6'd1) begin
                            state_reg <= dsr_pkg::ST_OFF;
                        end
                    end
                end
                dsr_pkg::ST_OFF: begin
                    // hold gain 0 until an on request, never against a trigger
                    if (!req.ext_off && (req.force_on || req.level_on)) begin
                        state_reg <= dsr_pkg::ST_UP;
                    end
                end
                dsr_pkg::ST_UP: begin
                    // a fresh trigger turns the ramp round from where it is
                    if (req.ext_off) begin
                        state_reg <= dsr_pkg::ST_DOWN;
                    end else if (tick) begin
                        step_reg <= step_reg + 6'd1;
                        if (step_reg == `DSR_STEPS - 6'd1) begin
                            state_reg <= dsr_pkg::ST_ON;
                        end
                    end
                end
                default: begin
                    // illegal code: recover to full gain
                    state_reg <= dsr_pkg::ST_ON;
                    step_reg  <= `DSR_STEPS;
                end
            endcase
        end
    end

endmodule : dsr_ramp
`default_nettype wire

/* logic/dsr_top.sv */
// soft off / soft on gain ramp controller with AXI4-Lite registers
//
// Notes on behaviour
// - link interrupt goes to pin zero or one
// - ramping works only with gain enable set
// - 32 equal steps over 2^(code+8) cycles
// - short power error starts soft off
// - long power error starts soft off
// - link error starts soft off when enabled
// - sync rotation off needs sync bit 0 set to 1
// - transmit pin falling edge starts soft off
// - forced off acts only at gain 1
// - forced on acts only at gain 0
// - long level may ramp gain back on
// - long limit is 13 bits, two registers
// - long monitor runs only when enabled
// - path page selects which copy is accessed
// - power is I^2+Q^2 of six MSBs
//
// The AXI4-Lite slave port was chosen for this implementation.
`default_nettype none
`include "dsr_cfg.svh"
module dsr_top (
    // clock and reset
    input  wire logic                    CLK,
    input  wire logic                    RST,
    // axi4-lite write address
    input  wire logic [15:0]             S_AXI_AWADDR,
    input  wire logic                    S_AXI_AWVALID,
    output logic                         S_AXI_AWREADY,
    // axi4-lite write data
    input  wire logic [31:0]             S_AXI_WDATA,
    input  wire logic [3:0]              S_AXI_WSTRB,
    input  wire logic                    S_AXI_WVALID,
    output logic                         S_AXI_WREADY,
    // axi4-lite write response
    output logic [1:0]                   S_AXI_BRESP,
    output logic                         S_AXI_BVALID,
    input  wire logic                    S_AXI_BREADY,
    // axi4-lite read address
    input  wire logic [15:0]             S_AXI_ARADDR,
    input  wire logic                    S_AXI_ARVALID,
    output logic                         S_AXI_ARREADY,
    // axi4-lite read data
    output logic [31:0]                  S_AXI_RDATA,
    output logic [1:0]                   S_AXI_RRESP,
    output logic                         S_AXI_RVALID,
    input  wire logic                    S_AXI_RREADY,
    // datapath samples and error sources, same clock
    input  wire logic [1:0][15:0]        I_DATA,
    input  wire logic [1:0][15:0]        Q_DATA,
    input  wire logic [1:0]              SHORT_PWR_ERR,
    input  wire logic                    LINK_ERR,
    input  wire logic                    SYNC_ROTATE,
    input  wire logic                    LINK_IRQ,
    // transmit enable pins, asynchronous
    input  wire logic [1:0]              TRANSMIT_ENABLE_PIN,
    // gain towards the datapath, 0..32 of 32; a trigger at step 0 of a ramp up wraps it to 63
    output logic [1:0][5:0]              GAIN_STEP,
    // interrupt pins
    output logic                         INTERRUPT_PIN_ZERO,
    output logic                         INTERRUPT_PIN_ONE
);
    localparam int NP = `DSR_NUM_PATHS;

    // paged register copies, one set per path
    logic [7:0]  path_reg [NP][`DSR_PATH_REGS];
    // global registers
    logic [7:0]  main_path_page_select_reg;   // bit per path
    logic        sync_ctl_reg;                // rotation gate
    logic        link_irq_pin_select_reg;     // 0 pin zero, 1 pin one

    // write channel state
    logic        awready_reg;
    logic        aw_full_reg;
    logic [13:0] aw_idx_reg;
    logic        wready_reg;
    logic        w_full_reg;
    logic [7:0]  w_data_reg;
    logic        w_lane_reg;                  // low byte strobe
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        wr_do;                       // both halves held
    logic [13:0] wr_off;                      // index within path set

    // read channel state
    logic        arready_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;
    logic [13:0] ar_idx;
    logic [13:0] rd_off;
    logic        rd_path;                     // copy shown on reads
    logic [7:0]  rd_byte;
    logic        rd_hit;

    // per path status
    logic [NP-1:0]       long_err_reg;
    logic [NP-1:0]       cause_long_reg;
    logic [NP-1:0][12:0] pwr_reg;
    logic [NP-1:0][5:0]  step_w;
    dsr_pkg::dsr_state_t state_w [NP];

    // pin synchronisers and edge history
    logic [NP-1:0] tx_s1_reg;
    logic [NP-1:0] tx_s2_reg;
    logic [NP-1:0] tx_s3_reg;
    logic [NP-1:0] tx_fall;

    // interrupt pins
    logic          interrupt_pin_zero_reg;
    logic          interrupt_pin_one_reg;

    // indices that the slave answers
    function automatic logic is_mapped(input logic [13:0] idx);
        is_mapped = (idx == `DSR_IDX_PAGE) || (idx == `DSR_IDX_SYNC) ||
                    (idx == `DSR_IDX_IRQMUX) || (idx == `DSR_IDX_STATUS) ||
                    (idx >= `DSR_IDX_GAIN && idx <= `DSR_IDX_LCTRL);
    endfunction : is_mapped

    // reset value of a path register
    function automatic logic [7:0] path_rst(input int k);
        unique case (k)
            0:       path_rst = `DSR_RST_GAIN;
            1:       path_rst = `DSR_RST_OFFEN;
            2:       path_rst = `DSR_RST_ONEN;
            3:       path_rst = `DSR_RST_LIMLO;
            4:       path_rst = `DSR_RST_LIMHI;
            default: path_rst = `DSR_RST_LCTRL;
        endcase
    endfunction : path_rst

    // writable mask of a path register
    function automatic logic [7:0] path_mask(input logic [13:0] k);
        unique case (k)
            14'h0000: path_mask = `DSR_WM_GAIN;
            14'h0001: path_mask = `DSR_WM_OFFEN;
            14'h0002: path_mask = `DSR_WM_ONEN;
            14'h0003: path_mask = `DSR_WM_LIMLO;
            14'h0004: path_mask = `DSR_WM_LIMHI;
            default:  path_mask = `DSR_WM_LCTRL;
        endcase
    endfunction : path_mask

    // ------------------------------------------------------------
    // write address channel: hold one address until the write is done
    assign wr_do  = aw_full_reg && w_full_reg && !bvalid_reg;
    assign wr_off = aw_idx_reg - `DSR_IDX_GAIN;

    always_ff @(posedge CLK) begin
        if (RST) begin
            awready_reg <= 1'b0;
            aw_full_reg <= 1'b0;
            aw_idx_reg  <= 14'h0000;
        end else if (S_AXI_AWVALID && awready_reg) begin
            aw_full_reg <= 1'b1;
            awready_reg <= 1'b0;
            aw_idx_reg  <= S_AXI_AWADDR[15:2];
        end else if (wr_do) begin
            aw_full_reg <= 1'b0;
            awready_reg <= 1'b1;
        end else if (!aw_full_reg) begin
            awready_reg <= 1'b1;
        end
    end

    // write data channel, taken independently of the address
    always_ff @(posedge CLK) begin
        if (RST) begin
            wready_reg <= 1'b0;
            w_full_reg <= 1'b0;
            w_data_reg <= 8'h00;
            w_lane_reg <= 1'b0;
        end else if (S_AXI_WVALID && wready_reg) begin
            w_full_reg <= 1'b1;
            wready_reg <= 1'b0;
            w_data_reg <= S_AXI_WDATA[7:0];
            w_lane_reg <= S_AXI_WSTRB[0];
        end else if (wr_do) begin
            w_full_reg <= 1'b0;
            wready_reg <= 1'b1;
        end else if (!w_full_reg) begin
            wready_reg <= 1'b1;
        end
    end

    // write response follows the completed pair
    always_ff @(posedge CLK) begin
        if (RST) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= `DSR_RESP_OKAY;
        end else if (wr_do) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= is_mapped(aw_idx_reg) ? `DSR_RESP_OKAY : `DSR_RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            bvalid_reg <= 1'b0;
        end
    end

    // global registers; only bits 7:0 exist, so lane 0 alone writes
    always_ff @(posedge CLK) begin
        if (RST) begin
            main_path_page_select_reg <= `DSR_RST_PAGE;
            sync_ctl_reg              <= 1'b0;
            link_irq_pin_select_reg   <= 1'b0;
        end else if (wr_do && w_lane_reg) begin
            if (aw_idx_reg == `DSR_IDX_PAGE) begin
                main_path_page_select_reg <= w_data_reg & `DSR_WM_PAGE;
            end
            if (aw_idx_reg == `DSR_IDX_SYNC) begin
                sync_ctl_reg <= w_data_reg[0];
            end
            if (aw_idx_reg == `DSR_IDX_IRQMUX) begin
                link_irq_pin_select_reg <= w_data_reg[0];
            end
        end
    end

    // paged registers: a write reaches every copy whose page bit is set
    always_ff @(posedge CLK) begin
        for (int p = 0; p < NP; p++) begin
            for (int k = 0; k < `DSR_PATH_REGS; k++) begin
                if (RST) begin
                    path_reg[p][k] <= path_rst(k);
                end else if (wr_do && w_lane_reg && main_path_page_select_reg[p] &&
                             aw_idx_reg >= `DSR_IDX_GAIN && aw_idx_reg <= `DSR_IDX_LCTRL &&
                             wr_off == 14'(k)) begin
                    path_reg[p][k] <= (path_reg[p][k] & ~path_mask(wr_off)) |
                                      (w_data_reg & path_mask(wr_off));
                end
            end
        end
    end

    // ------------------------------------------------------------
    // read decode; lowest selected page is shown, path 0 when none
    assign ar_idx  = S_AXI_ARADDR[15:2];
    assign rd_off  = ar_idx - `DSR_IDX_GAIN;
    assign rd_path = !main_path_page_select_reg[0] && main_path_page_select_reg[1];
    assign rd_hit  = is_mapped(ar_idx);

    always_comb begin
        rd_byte = 8'h00;
        if (ar_idx == `DSR_IDX_PAGE) begin
            rd_byte = main_path_page_select_reg;
        end else if (ar_idx == `DSR_IDX_SYNC) begin
            rd_byte = {7'h00, sync_ctl_reg};
        end else if (ar_idx == `DSR_IDX_IRQMUX) begin
            rd_byte = {7'h00, link_irq_pin_select_reg};
        end else if (ar_idx == `DSR_IDX_STATUS) begin
            // live state of the selected path
            rd_byte = {long_err_reg[rd_path], state_w[rd_path] != dsr_pkg::ST_ON &&
                       state_w[rd_path] != dsr_pkg::ST_OFF, step_w[rd_path]};
        end else if (ar_idx >= `DSR_IDX_GAIN && ar_idx <= `DSR_IDX_LCTRL) begin
            rd_byte = path_reg[rd_path][rd_off[2:0]];
        end
    end

    // read channel: one outstanding read, data one cycle after the address
    always_ff @(posedge CLK) begin
        if (RST) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
            rresp_reg   <= `DSR_RESP_OKAY;
        end else if (S_AXI_ARVALID && arready_reg) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rdata_reg   <= {24'h00_0000, rd_byte};
            rresp_reg   <= rd_hit ? `DSR_RESP_OKAY : `DSR_RESP_SLVERR;
        end else if (rvalid_reg && S_AXI_RREADY) begin
            rvalid_reg  <= 1'b0;
            arready_reg <= 1'b1;
        end else if (!rvalid_reg) begin
            arready_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // transmit pins: two flops, then a third for the edge
    always_ff @(posedge CLK) begin
        if (RST) begin
            tx_s1_reg <= '0;
            tx_s2_reg <= '0;
            tx_s3_reg <= '0;
        end else begin
            tx_s1_reg <= TRANSMIT_ENABLE_PIN;
            tx_s2_reg <= tx_s1_reg;
            tx_s3_reg <= tx_s2_reg;
        end
    end
    assign tx_fall = tx_s3_reg & ~tx_s2_reg;

    // link interrupt routing, registered towards the pins
    always_ff @(posedge CLK) begin
        if (RST) begin
            interrupt_pin_zero_reg <= 1'b0;
            interrupt_pin_one_reg <= 1'b0;
        end else begin
            interrupt_pin_zero_reg <= LINK_IRQ && !link_irq_pin_select_reg;
            interrupt_pin_one_reg <= LINK_IRQ && link_irq_pin_select_reg;
        end
    end

    // ------------------------------------------------------------
    // per path monitor, trigger gathering and ramp
    for (genvar gp = 0; gp < NP; gp++) begin : g_path
        logic signed [11:0] isq;           // square of I top bits
        logic signed [11:0] qsq;           // square of Q top bits
        logic [12:0]        limit;         // long power limit
        logic               mon_en;        // long monitor enabled
        logic               long_trig;     // long error soft off
        dsr_pkg::dsr_req_t  req;

        // only the six top bits count; squares are never negative
        assign isq = $signed(I_DATA[gp][15:10]) * $signed(I_DATA[gp][15:10]);
        assign qsq = $signed(Q_DATA[gp][15:10]) * $signed(Q_DATA[gp][15:10]);
        assign limit  = {path_reg[gp][4][4:0], path_reg[gp][3]};
        assign mon_en = path_reg[gp][5][`DSR_B_MON];

        // power and long error, held cleared while disabled
        always_ff @(posedge CLK) begin
            if (RST || !mon_en) begin
                pwr_reg[gp]      <= 13'h0000;
                long_err_reg[gp] <= 1'b0;
            end else begin
                pwr_reg[gp]      <= {1'b0, isq} + {1'b0, qsq};
                long_err_reg[gp] <= pwr_reg[gp] > limit;
            end
        end

        assign long_trig = path_reg[gp][1][`DSR_B_LONG] && long_err_reg[gp];

        // remember a long error shutdown so the level may undo only that
        always_ff @(posedge CLK) begin
            if (RST) begin
                cause_long_reg[gp] <= 1'b0;
            end else if (long_trig && state_w[gp] != dsr_pkg::ST_OFF) begin
                cause_long_reg[gp] <= 1'b1;
            end else if (state_w[gp] == dsr_pkg::ST_UP) begin
                cause_long_reg[gp] <= 1'b0;
            end
        end

        // soft off sources
        assign req.ext_off =
            (path_reg[gp][1][`DSR_B_SHORT] && SHORT_PWR_ERR[gp]) ||
            long_trig ||
            (path_reg[gp][1][`DSR_B_LINK] && LINK_ERR) ||
            (path_reg[gp][1][`DSR_B_ROT] && sync_ctl_reg && SYNC_ROTATE) ||
            (path_reg[gp][1][`DSR_B_TX] && tx_fall[gp]);
        assign req.force_off = path_reg[gp][1][`DSR_B_FOFF];
        assign req.force_on  = path_reg[gp][2][`DSR_B_FON];
        // level soft on once the long power is back under the limit
        assign req.level_on  = path_reg[gp][2][`DSR_B_LVL] && cause_long_reg[gp] &&
                               mon_en && !long_err_reg[gp];

        dsr_ramp u_ramp (
            .clk      (CLK),
            .rst      (RST),
            .gain_en  (path_reg[gp][0][`DSR_B_GAIN_EN]),
            .rate     (path_reg[gp][0][2:0]),
            .req      (req),
            .step_reg (step_w[gp]),
            .state_reg(state_w[gp])
        );
    end

    // ------------------------------------------------------------
    // outputs, all from flip-flops
    assign S_AXI_AWREADY      = awready_reg;
    assign S_AXI_WREADY       = wready_reg;
    assign S_AXI_BVALID       = bvalid_reg;
    assign S_AXI_BRESP        = bresp_reg;
    assign S_AXI_ARREADY      = arready_reg;
    assign S_AXI_RVALID       = rvalid_reg;
    assign S_AXI_RDATA        = rdata_reg;
    assign S_AXI_RRESP        = rresp_reg;
    assign GAIN_STEP          = step_w;
    assign INTERRUPT_PIN_ZERO = interrupt_pin_zero_reg;
    assign INTERRUPT_PIN_ONE  = interrupt_pin_one_reg;

endmodule : dsr_top
`default_nettype wire

/* verif/dsr_chk.sv */
// port checker of the soft ramp block
`default_nettype none
module dsr_chk (
    // clock and reset
    input wire logic            CLK,
    input wire logic            RST,
    // register bus handshakes
    input wire logic            S_AXI_AWVALID,
    input wire logic            S_AXI_AWREADY,
    input wire logic            S_AXI_WVALID,
    input wire logic            S_AXI_WREADY,
    input wire logic            S_AXI_BVALID,
    input wire logic            S_AXI_BREADY,
    input wire logic            S_AXI_ARVALID,
    input wire logic            S_AXI_ARREADY,
    input wire logic            S_AXI_RVALID,
    input wire logic            S_AXI_RREADY,
    input wire logic [31:0]     S_AXI_RDATA,
    // interrupt and gain
    input wire logic            LINK_IRQ,
    input wire logic [1:0][5:0] GAIN_STEP,
    input wire logic            INTERRUPT_PIN_ZERO,
    input wire logic            INTERRUPT_PIN_ONE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // one gain decrement on path zero
    sequence dec_s;
        GAIN_STEP[0] < $past(GAIN_STEP[0]);
    endsequence
    chk_irq_route: assert property (!$past(RST) |->
        (INTERRUPT_PIN_ZERO | INTERRUPT_PIN_ONE) == $past(LINK_IRQ)) else $error("irq lost");
    chk_irq_single: assert property (!(INTERRUPT_PIN_ZERO && INTERRUPT_PIN_ONE))
        else $error("irq on both pins");
    chk_gain_max: assert property (GAIN_STEP[0] <= 6'h20) else $error("gain above 32");
    chk_gain_unit: assert property (dec_s |-> $past(GAIN_STEP[0]) == GAIN_STEP[0] + 6'h01)
        else $error("gain step not one");
    chk_step_gap: assert property (dec_s |=> (GAIN_STEP[0] >= $past(GAIN_STEP[0]))[*7])
        else $error("gain steps too close");
    chk_b_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
        && S_AXI_WREADY |=> ##1 S_AXI_BVALID) else $error("no write answer");
    chk_r_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=>
        S_AXI_RVALID && S_AXI_RDATA[31:8] == 24'h00_0000) else $error("bad read answer");
    chk_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
        else $error("write answer dropped");
    chk_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
        S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read answer dropped");
endmodule : dsr_chk
bind dsr_top dsr_chk u_chk (.*);
`default_nettype wire

/* verif/dsr_tb.sv */
// self-checking bench of the soft ramp block
`default_nettype none
`include "dsr_cfg.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // port signals share the top port names so the instance binds by name
    logic CLK = 0, RST = 1, S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0, LINK_IRQ = 0;
    logic S_AXI_ARVALID = 0, S_AXI_RREADY = 0, LINK_ERR = 0, SYNC_ROTATE = 0;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic INTERRUPT_PIN_ZERO, INTERRUPT_PIN_ONE;
    logic [15:0] S_AXI_AWADDR = '0, S_AXI_ARADDR = '0;
    logic [31:0] S_AXI_WDATA = '0, S_AXI_RDATA;
    logic [3:0] S_AXI_WSTRB = 4'hF;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP, SHORT_PWR_ERR = '0, TRANSMIT_ENABLE_PIN = 2'h3;
    logic [1:0][15:0] I_DATA = '0, Q_DATA = '0;
    logic [1:0][5:0] GAIN_STEP;
    int failures = 0, checks = 0, n;
    logic [7:0] rv;
    logic [1:0] rr, br;
    always #12.5 CLK = ~CLK;
    dsr_top u_dut (.*);
    task chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s exp %h seen %h", s, exp, seen);
        end
    endtask : chk
    task wt(input int c);
        repeat (c) @(posedge CLK);
    endtask : wt
    // write one register word, bready held until the answer
    task wr(input logic [13:0] i, input logic [7:0] d);
        @(posedge CLK);
        S_AXI_AWADDR <= {i, 2'b00};
        S_AXI_WDATA <= {24'h00_0000, d};
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        do @(posedge CLK); while (!(S_AXI_AWREADY && S_AXI_WREADY));
        S_AXI_AWVALID <= 1'b0;
        S_AXI_WVALID <= 1'b0;
        // late bready, so the answer must stand a while
        wt(2);
        S_AXI_BREADY <= 1'b1;
        do @(posedge CLK); while (!S_AXI_BVALID);
        br = S_AXI_BRESP;
        S_AXI_BREADY <= 1'b0;
    endtask : wr
    // read one register word into rv and rr
    task rd(input logic [13:0] i);
        @(posedge CLK);
        S_AXI_ARADDR <= {i, 2'b00};
        S_AXI_ARVALID <= 1'b1;
        do @(posedge CLK); while (!S_AXI_ARREADY);
        S_AXI_ARVALID <= 1'b0;
        wt(1);
        S_AXI_RREADY <= 1'b1;
        do @(posedge CLK); while (!S_AXI_RVALID);
        rv = S_AXI_RDATA[7:0];
        rr = S_AXI_RRESP;
        S_AXI_RREADY <= 1'b0;
    endtask : rd
    task t_regs;
        rd(`DSR_IDX_OFFEN); chk("off enables", rv, 8'hC6);
        rd(`DSR_IDX_ONEN); chk("on enables", rv, 8'h40);
        rd(`DSR_IDX_LCTRL); chk("monitor ctrl", rv, 8'h00);
        wr(`DSR_IDX_LIMHI, 8'hFF); rd(`DSR_IDX_LIMHI); chk("limit high", rv, 8'h1F);
        chk("write resp", {6'h00, br}, 8'h00);
        rd(14'h0100); chk("unmapped resp", {6'h00, rr}, {6'h00, `DSR_RESP_SLVERR});
        wr(14'h0100, 8'h55);
        chk("unmapped wr", {6'h00, br}, {6'h00, `DSR_RESP_SLVERR});
    endtask : t_regs
    task t_irq;
        LINK_IRQ <= 1'b1; wt(3);
        chk("pins sel0", {6'h00, INTERRUPT_PIN_ONE, INTERRUPT_PIN_ZERO}, 8'h01);
        wr(`DSR_IDX_IRQMUX, 8'h01); wt(3);
        chk("pins sel1", {6'h00, INTERRUPT_PIN_ONE, INTERRUPT_PIN_ZERO}, 8'h02);
        LINK_IRQ <= 1'b0;
    endtask : t_irq
    // force off on path zero only, then time the ramp at code zero
    task t_ramp;
        wr(`DSR_IDX_PAGE, 8'h01);
        wr(`DSR_IDX_OFFEN, 8'hC7); wt(20);
        chk("gain ramp off", {2'b00, GAIN_STEP[0]}, 8'h20);
        wr(`DSR_IDX_GAIN, 8'h80);
        while (GAIN_STEP[0] !== 6'h1F) @(posedge CLK);
        n = 0;
        while (GAIN_STEP[0] !== 6'h00) begin
            @(posedge CLK);
            n++;
        end
        chk("ramp cycles", n[7:0], 8'hF8); // 31 steps of 8
        chk("other path", {2'b00, GAIN_STEP[1]}, 8'h20);
        wr(`DSR_IDX_OFFEN, 8'hC6); wr(`DSR_IDX_ONEN, 8'hC0); wt(300);
        chk("gain forced on", {2'b00, GAIN_STEP[0]}, 8'h20);
    endtask : t_ramp
    task t_trig;
        SHORT_PWR_ERR <= 2'b01; wt(300);
        chk("short err hold", {2'b00, GAIN_STEP[0]}, 8'h00);
        SHORT_PWR_ERR <= 2'b00; wt(300);
        chk("after short", {2'b00, GAIN_STEP[0]}, 8'h20);
        // link trigger disabled, rotation gated off by the sync bit
        LINK_ERR <= 1'b1; SYNC_ROTATE <= 1'b1; wt(20);
        chk("link rot idle", {2'b00, GAIN_STEP[0]}, 8'h20);
        LINK_ERR <= 1'b0; SYNC_ROTATE <= 1'b0;
        wr(`DSR_IDX_ONEN, 8'h40); TRANSMIT_ENABLE_PIN <= 2'b10; wt(300);
        chk("pin fall", {2'b00, GAIN_STEP[0]}, 8'h00);
    endtask : t_trig
    // long monitor on path zero: error ramps off, quiet level ramps back on
    task t_long;
        wr(`DSR_IDX_ONEN, 8'hC0); wt(300);
        wr(`DSR_IDX_ONEN, 8'h40); wr(`DSR_IDX_LIMHI, 8'h00);
        I_DATA[0] <= 16'h8000;
        wr(`DSR_IDX_LCTRL, 8'h80); wt(300);
        chk("long err off", {2'b00, GAIN_STEP[0]}, 8'h00);
        I_DATA[0] <= 16'h0000; wt(300);
        chk("level on", {2'b00, GAIN_STEP[0]}, 8'h20);
    endtask : t_long
    task final_report;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : final_report
    initial begin
        wt(20); RST <= 1'b0;
        t_regs; t_irq; t_ramp; t_trig; t_long;
        final_report;
    end
    // hang guard, far beyond the few thousand cycles the tests need
    initial begin
        wt(20000); failures++; final_report;
    end
endmodule : testbench
`default_nettype wire
